// >>> design/fpal_consts.svh
// Constants for the float add-with-load and compare datapath.
// Assumes inclusion by bare name from the design package and core.
`ifndef FPAL_CONSTS_SVH
`define FPAL_CONSTS_SVH

// ****************************************************************
// Instruction encodings
// ****************************************************************
`define FPAL_PAIR_LSW_HI   12'hE31
`define FPAL_CMPR_LSW      16'hE694
`define FPAL_CMPR_MSW_HI   10'h000
`define FPAL_CMPI_LSW_HI   10'h3A0

// ****************************************************************
// Single-precision layout
// ****************************************************************
`define FPAL_EXP_MAX       8'hFF
`define FPAL_POS_ZERO      32'h0000_0000
`define FPAL_POS_INF       32'h7F80_0000
`define FPAL_NEG_INF       32'hFF80_0000
`define FPAL_ALIGN_LIMIT   8'h1B
`define FPAL_EXP_OVF       10'sh0FF

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define FPAL_ADDR_STATUS   8'h00
`define FPAL_ADDR_INT_STAT 8'h04
`define FPAL_ADDR_INT_MASK 8'h08
`define FPAL_ADDR_FREG     8'h20
`define FPAL_ADDR_FREG_END 8'h3C

// ****************************************************************
// Status register bit positions
// ****************************************************************
`define FPAL_BIT_LVF       0
`define FPAL_BIT_LUF       1
`define FPAL_BIT_NF        2
`define FPAL_BIT_ZF        3
`define FPAL_BIT_NI        4
`define FPAL_BIT_ZI        5
`define FPAL_BIT_TF        6
`define FPAL_STATUS_W      7
`define FPAL_STATUS_RST    7'h00

// Interrupt status bits
`define FPAL_IRQ_OVF       0
`define FPAL_IRQ_UNF       1
`define FPAL_IRQ_W         2
`define FPAL_IRQ_RST       2'h0

`endif

// >>> design/fpal_pkg.sv
// Types shared by the float add-with-load and compare datapath.
// Assumes the constants header is on the include path.
`include "fpal_consts.svh"

package fpal_pkg;
  typedef logic [31:0] fpal_word_t;
  typedef logic [15:0] fpal_half_t;
  typedef logic [2:0]  fpal_sel_t;
  typedef logic [7:0]  fpal_addr_t;
  // Gray-coded operation class
  typedef enum logic [1:0] {
    FPAL_OP_NONE = 2'h0,
    FPAL_OP_PAIR = 2'h1,
    FPAL_OP_CMPR = 2'h3,
    FPAL_OP_CMPI = 2'h2
  } fpal_op_t;
endpackage : fpal_pkg

// >>> design/fpal_core.sv
// Float add with parallel 32-bit load, register and immediate compare.
// Assumes host issues instruction words and returns load data in the
// issue cycle, on the same clock and reset.
`include "fpal_consts.svh"

module fpal_core #(
  parameter int NUM_REGS = 8
) (
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  input  wire logic               instr_valid_i,
  input  wire fpal_pkg::fpal_half_t instr_lsw_i,
  input  wire fpal_pkg::fpal_half_t instr_msw_i,
  input  wire fpal_pkg::fpal_word_t mem_rdata_i,
  output logic                    mem_read_o,
  output logic [7:0]              memory_operand_o,
  output logic [6:0]              flags_o,
  input  wire fpal_pkg::fpal_addr_t reg_addr_i,
  input  wire fpal_pkg::fpal_word_t reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output fpal_pkg::fpal_word_t    reg_rdata_o,
  output logic                    irq_o
);
  import fpal_pkg::*;

  if (NUM_REGS != 8) begin : g_chk
    $error("fpal_core serves exactly eight registers");
  end

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Denormals and both zeros become plain zero
  function automatic fpal_word_t flush(input fpal_word_t x);
    flush = (x[30:23] == 8'h00) ? `FPAL_POS_ZERO : x;
  endfunction

  // Ordering key: sign-magnitude to unsigned
  function automatic fpal_word_t cmp_key(input fpal_word_t x);
    fpal_word_t v;
    v = flush(x);
    if (v[30:23] == `FPAL_EXP_MAX) begin
      v = v[31] ? `FPAL_NEG_INF : `FPAL_POS_INF;
    end
    cmp_key = v[31] ? ~v : {1'b1, v[30:0]};
  endfunction

  function automatic logic [4:0] lzc(input logic [26:0] x);
    lzc = 5'h1B;
    for (int i = 0; i < 27; i++) begin
      if (x[i]) begin
        lzc = 5'(26 - i);
      end
    end
  endfunction

  // ****************************************************************
  // Decode
  // ****************************************************************
  fpal_op_t   op;
  fpal_sel_t  add_source_one;
  fpal_sel_t  add_source_two;
  fpal_sel_t  add_dest_reg;
  fpal_sel_t  load_dest_reg;
  fpal_sel_t  cmp_first;
  fpal_sel_t  compare_second_reg;
  fpal_word_t upper_half_immediate;

  always_comb begin
    op = FPAL_OP_NONE;
    if (instr_valid_i) begin
      if (instr_lsw_i[15:4] == `FPAL_PAIR_LSW_HI) begin
        op = FPAL_OP_PAIR;
      end else if (instr_lsw_i == `FPAL_CMPR_LSW &&
                   instr_msw_i[15:6] == `FPAL_CMPR_MSW_HI) begin
        op = FPAL_OP_CMPR;
      end else if (instr_lsw_i[15:6] == `FPAL_CMPI_LSW_HI) begin
        op = FPAL_OP_CMPI;
      end
    end
  end

  assign add_source_two       = instr_lsw_i[3:1];
  assign add_source_one       = {instr_lsw_i[0], instr_msw_i[15:14]};
  assign add_dest_reg         = instr_msw_i[13:11];
  assign load_dest_reg        = instr_msw_i[10:8];
  assign cmp_first            = instr_msw_i[2:0];
  assign compare_second_reg   = instr_msw_i[5:3];
  assign upper_half_immediate = {instr_lsw_i[5:0], instr_msw_i[15:6],
                                 16'h0000};

  // Host resolves direct or indirect addressing from this field
  assign mem_read_o       = (op == FPAL_OP_PAIR);
  assign memory_operand_o = instr_msw_i[7:0];

  // ****************************************************************
  // Register file
  // ****************************************************************
  fpal_word_t freg_q [NUM_REGS];
  fpal_word_t src_a;
  fpal_word_t src_b;

  assign src_a = freg_q[add_source_one];
  assign src_b = freg_q[add_source_two];

  // ****************************************************************
  // Adder stage one: align and add
  // ****************************************************************
  fpal_word_t  fa;
  fpal_word_t  fb;
  fpal_word_t  big;
  fpal_word_t  sml;
  logic [7:0]  diff;
  logic [26:0] ma_ext;
  logic [26:0] mb_ext;
  logic [53:0] wide;
  logic [26:0] b_al;
  logic [27:0] sum_d;
  logic        inf_d;
  logic        inf_sign_d;

  always_comb begin
    fa = flush(src_a);
    fb = flush(src_b);
    inf_d = (fa[30:23] == `FPAL_EXP_MAX) || (fb[30:23] == `FPAL_EXP_MAX);
    inf_sign_d = (fa[30:23] == `FPAL_EXP_MAX) ? fa[31] : fb[31];
    if (fa[30:0] >= fb[30:0]) begin
      big = fa;
      sml = fb;
    end else begin
      big = fb;
      sml = fa;
    end
    diff   = big[30:23] - sml[30:23];
    ma_ext = {(big[30:23] != 8'h00), big[22:0], 3'b000};
    mb_ext = {(sml[30:23] != 8'h00), sml[22:0], 3'b000};
    if (diff > `FPAL_ALIGN_LIMIT) begin
      diff = `FPAL_ALIGN_LIMIT;
    end
    // Sticky keeps rounding exact after a far shift
    wide = {mb_ext, 27'h0} >> diff;
    b_al = {wide[53:28], wide[27] | (|wide[26:0])};
    if (big[31] != sml[31]) begin
      sum_d = {1'b0, ma_ext} - {1'b0, b_al};
    end else begin
      sum_d = {1'b0, ma_ext} + {1'b0, b_al};
    end
  end

  logic        s1_vld_q;
  fpal_sel_t   s1_dest_q;
  logic [27:0] s1_sum_q;
  logic [7:0]  s1_exp_q;
  logic        s1_sign_q;
  logic        s1_inf_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_vld_q  <= 1'b0;
      s1_dest_q <= 3'h0;
      s1_sum_q  <= 28'h0;
      s1_exp_q  <= 8'h00;
      s1_sign_q <= 1'b0;
      s1_inf_q  <= 1'b0;
    end else begin
      s1_vld_q  <= (op == FPAL_OP_PAIR);
      s1_dest_q <= add_dest_reg;
      s1_sum_q  <= sum_d;
      s1_exp_q  <= big[30:23];
      s1_sign_q <= inf_d ? inf_sign_d : big[31];
      s1_inf_q  <= inf_d;
    end
  end

  // ****************************************************************
  // Adder stage two: normalise, round, range check
  // ****************************************************************
  logic [26:0]       nm;
  logic [4:0]        lz;
  logic signed [9:0] e;
  logic              rup;
  logic [24:0]       mant;
  fpal_word_t        add_res;
  logic              add_ovf;
  logic              add_unf;

  always_comb begin
    lz = lzc(s1_sum_q[26:0]);
    if (s1_sum_q[27]) begin
      nm = {s1_sum_q[27:2], s1_sum_q[1] | s1_sum_q[0]};
      e  = $signed({2'b00, s1_exp_q}) + 10'sd1;
    end else begin
      nm = s1_sum_q[26:0] << lz;
      e  = $signed({2'b00, s1_exp_q}) - $signed({5'h00, lz});
    end
    // Round to nearest, ties to even
    rup  = nm[2] & (nm[1] | nm[0] | nm[3]);
    mant = {1'b0, nm[26:3]} + {24'h0, rup};
    if (mant[24]) begin
      e = e + 10'sd1;
    end
    add_ovf = 1'b0;
    add_unf = 1'b0;
    add_res = {s1_sign_q, e[7:0], mant[22:0]};
    if (s1_inf_q) begin
      add_res = s1_sign_q ? `FPAL_NEG_INF : `FPAL_POS_INF;
    end else if (s1_sum_q == 28'h0) begin
      add_res = `FPAL_POS_ZERO;
    end else if (e >= `FPAL_EXP_OVF) begin
      add_ovf = 1'b1;
      add_res = s1_sign_q ? `FPAL_NEG_INF : `FPAL_POS_INF;
    end else if (e <= 10'sd0) begin
      add_unf = 1'b1;
      add_res = `FPAL_POS_ZERO;
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Same-edge clash with a later load is excluded by the host
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        freg_q[i] <= `FPAL_POS_ZERO;
      end
    end else begin
      if (s1_vld_q) begin
        freg_q[s1_dest_q] <= add_res;
      end
      if (op == FPAL_OP_PAIR) begin
        freg_q[load_dest_reg] <= mem_rdata_i;
      end
    end
  end

  // ****************************************************************
  // Compare
  // ****************************************************************
  fpal_word_t key_a;
  fpal_word_t key_b;

  always_comb begin
    key_a = cmp_key(freg_q[cmp_first]);
    if (op == FPAL_OP_CMPI) begin
      key_b = cmp_key(upper_half_immediate);
    end else begin
      key_b = cmp_key(freg_q[compare_second_reg]);
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  logic [`FPAL_STATUS_W-1:0] fpu_status_reg_q;
  logic                      stat_wr;

  assign stat_wr = reg_wr_i && (reg_addr_i == `FPAL_ADDR_STATUS);
  assign flags_o = fpu_status_reg_q;

  // Float and integer sign/zero flags
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fpu_status_reg_q[`FPAL_BIT_ZI:`FPAL_BIT_NF] <= 4'h0;
    end else if (op == FPAL_OP_PAIR) begin
      fpu_status_reg_q[`FPAL_BIT_NF] <= mem_rdata_i[31] &&
                                        (mem_rdata_i[30:23] != 8'h00);
      fpu_status_reg_q[`FPAL_BIT_ZF] <= (mem_rdata_i[30:23] == 8'h00);
      fpu_status_reg_q[`FPAL_BIT_NI] <= mem_rdata_i[31];
      fpu_status_reg_q[`FPAL_BIT_ZI] <= (mem_rdata_i == 32'h0000_0000);
    end else if (op == FPAL_OP_CMPR || op == FPAL_OP_CMPI) begin
      fpu_status_reg_q[`FPAL_BIT_ZF] <= (key_a == key_b);
      fpu_status_reg_q[`FPAL_BIT_NF] <= (key_a < key_b);
    end
  end

  // Test flag: software only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fpu_status_reg_q[`FPAL_BIT_TF] <= 1'b0;
    end else if (stat_wr) begin
      fpu_status_reg_q[`FPAL_BIT_TF] <= reg_wdata_i[`FPAL_BIT_TF];
    end
  end

  // Latched flags: set wins over write-one-to-clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fpu_status_reg_q[`FPAL_BIT_LUF:`FPAL_BIT_LVF] <= 2'h0;
    end else begin
      fpu_status_reg_q[`FPAL_BIT_LVF] <= (s1_vld_q && add_ovf) ||
        (fpu_status_reg_q[`FPAL_BIT_LVF] &&
         !(stat_wr && reg_wdata_i[`FPAL_BIT_LVF]));
      fpu_status_reg_q[`FPAL_BIT_LUF] <= (s1_vld_q && add_unf) ||
        (fpu_status_reg_q[`FPAL_BIT_LUF] &&
         !(stat_wr && reg_wdata_i[`FPAL_BIT_LUF]));
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  logic [`FPAL_IRQ_W-1:0] int_stat_q;
  logic [`FPAL_IRQ_W-1:0] int_mask_q;
  logic [`FPAL_IRQ_W-1:0] int_set;
  logic [`FPAL_IRQ_W-1:0] int_clr;

  assign int_set = {s1_vld_q && add_unf, s1_vld_q && add_ovf};
  assign int_clr = (reg_wr_i && reg_addr_i == `FPAL_ADDR_INT_STAT) ?
                   reg_wdata_i[`FPAL_IRQ_W-1:0] : `FPAL_IRQ_RST;
  assign irq_o   = |(int_stat_q & int_mask_q);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      int_stat_q <= `FPAL_IRQ_RST;
    end else begin
      int_stat_q <= int_set | (int_stat_q & ~int_clr);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      int_mask_q <= `FPAL_IRQ_RST;
    end else if (reg_wr_i && reg_addr_i == `FPAL_ADDR_INT_MASK) begin
      int_mask_q <= reg_wdata_i[`FPAL_IRQ_W-1:0];
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  // Unmapped addresses read zero
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_addr_i == `FPAL_ADDR_STATUS) begin
      reg_rdata_o <= {25'h0, fpu_status_reg_q};
    end else if (reg_addr_i == `FPAL_ADDR_INT_STAT) begin
      reg_rdata_o <= {30'h0, int_stat_q};
    end else if (reg_addr_i == `FPAL_ADDR_INT_MASK) begin
      reg_rdata_o <= {30'h0, int_mask_q};
    end else if (reg_addr_i >= `FPAL_ADDR_FREG &&
                 reg_addr_i <= `FPAL_ADDR_FREG_END &&
                 reg_addr_i[1:0] == 2'b00) begin
      reg_rdata_o <= freg_q[reg_addr_i[4:2]];
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

endmodule // fpal_core

// >>> verification/fpal_core_chk.sv
// Checker for the float add-with-load and compare datapath.
// Assumes it is bound onto fpal_core and sees only its ports.
// ****
// Port checker
// ****
module fpal_core_chk #(
  parameter int NUM_REGS = 8
) (
  input wire logic                 clk_i,
  input wire logic                 resetn_i,
  input wire logic                 instr_valid_i,
  input wire fpal_pkg::fpal_half_t instr_lsw_i,
  input wire fpal_pkg::fpal_half_t instr_msw_i,
  input wire fpal_pkg::fpal_word_t mem_rdata_i,
  input wire logic                 mem_read_o,
  input wire logic [7:0]           memory_operand_o,
  input wire logic [6:0]           flags_o,
  input wire fpal_pkg::fpal_addr_t reg_addr_i,
  input wire fpal_pkg::fpal_word_t reg_wdata_i,
  input wire logic                 reg_wr_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import fpal_pkg::*;
  logic pair;
  logic cmp;
  logic st_wr;
  assign pair  = instr_valid_i && instr_lsw_i[15:4] == 12'hE31;
  assign cmp   = instr_valid_i && ((instr_lsw_i == 16'hE694
                 && instr_msw_i[15:6] == 10'h000)
                 || instr_lsw_i[15:6] == 10'h3A0);
  assign st_wr = reg_wr_i && reg_addr_i == 8'h00;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  dec_pair_a: assert property (
    mem_read_o == pair) else $error("load strobe disagrees with decode");
  mem_field_a: assert property (
    pair |-> memory_operand_o == instr_msw_i[7:0])
    else $error("memory field not passed to host");
  int_flags_a: assert property (
    pair |=> flags_o[4] == $past(mem_rdata_i[31])
    && flags_o[5] == ($past(mem_rdata_i) == 32'h0000_0000))
    else $error("integer flags wrong after load");
  flt_flags_a: assert property (
    pair |=> flags_o[3] == ($past(mem_rdata_i[30:23]) == 8'h00)
    && flags_o[2] == ($past(mem_rdata_i[31])
    && $past(mem_rdata_i[30:23]) != 8'h00))
    else $error("float flags wrong after load");
  cmp_keep_a: assert property (
    cmp && !st_wr |=> flags_o[6:4] == $past(flags_o[6:4]))
    else $error("compare touched other flags");
  cmp_excl_a: assert property (
    cmp |=> !(flags_o[3] && flags_o[2]))
    else $error("compare set zero and negative together");
  tf_keep_a: assert property (
    !st_wr |=> $stable(flags_o[6])) else $error("test flag changed");
  lvf_rise_a: assert property (
    $rose(flags_o[0]) |-> $past(pair, 2))
    else $error("overflow flag rose off the add slot");
  lvf_hold_a: assert property (
    flags_o[0] && !(st_wr && reg_wdata_i[0]) |=> flags_o[0])
    else $error("latched overflow lost");
  cover property (pair);
  cover property (cmp ##1 flags_o[3]);
  cover property ($rose(flags_o[0]));
endmodule // fpal_core_chk

bind fpal_core fpal_core_chk #(.NUM_REGS(NUM_REGS)) fpal_core_chk_inst (
  .clk_i(clk_i), .resetn_i(resetn_i), .instr_valid_i(instr_valid_i),
  .instr_lsw_i(instr_lsw_i), .instr_msw_i(instr_msw_i),
  .mem_rdata_i(mem_rdata_i), .mem_read_o(mem_read_o),
  .memory_operand_o(memory_operand_o), .flags_o(flags_o),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i));

// >>> verification/fpal_host_mem.sv
// Host data memory model answering paired loads in the issue cycle.
// Assumes the bench preloads mem_q and shares the core clock.
// ****
// Host memory
// ****
module fpal_host_mem (
  input  wire logic            clk_i,
  input  wire logic            mem_read_i,
  input  wire logic [7:0]      memory_operand_i,
  output fpal_pkg::fpal_word_t mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import fpal_pkg::*;
  fpal_word_t mem_q [256];
  fpal_word_t last_q = 32'h0000_0000;
  // Direct addressing only; idle bus shows inverted data, not a hold
  assign mem_rdata_o = mem_read_i ? mem_q[memory_operand_i] : ~last_q;
  always @(posedge clk_i) begin
    if (mem_read_i) begin
      last_q <= mem_rdata_o;
    end
  end
endmodule // fpal_host_mem

// >>> verification/tb.sv
// Self-checking bench for the float add-with-load and compare datapath.
// Assumes package, core, checker and host memory model compiled first.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fpal_pkg::*;
  // ****
  // Signals and instances
  // ****
  logic       clk_i         = 1'b0;
  logic       resetn_i      = 1'b0;
  logic       instr_valid_i = 1'b0;
  fpal_half_t instr_lsw_i   = 16'h0000;
  fpal_half_t instr_msw_i   = 16'h0000;
  fpal_addr_t reg_addr_i    = 8'h00;
  fpal_word_t reg_wdata_i   = 32'h0000_0000;
  logic       reg_wr_i      = 1'b0;
  logic       reg_rd_i      = 1'b0;
  fpal_word_t mem_rdata_i;
  fpal_word_t reg_rdata_o;
  logic       mem_read_o;
  logic       irq_o;
  logic [7:0] memory_operand_o;
  logic [6:0] flags_o;
  int         fails         = 0;
  int         compares      = 0;
  always #12.5 clk_i = ~clk_i;
  fpal_core fpal_core_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .instr_valid_i(instr_valid_i),
    .instr_lsw_i(instr_lsw_i), .instr_msw_i(instr_msw_i),
    .mem_rdata_i(mem_rdata_i), .mem_read_o(mem_read_o),
    .memory_operand_o(memory_operand_o), .flags_o(flags_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
  fpal_host_mem fpal_host_mem_inst (.clk_i(clk_i), .mem_read_i(mem_read_o),
    .memory_operand_i(memory_operand_o), .mem_rdata_o(mem_rdata_i));
  // ****
  // Shared tasks
  // ****
  task automatic chk(string what, fpal_word_t exp, fpal_word_t got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(fpal_addr_t a, fpal_word_t d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rdchk(fpal_addr_t a, fpal_word_t exp, string what);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(what, exp, reg_rdata_o);
  endtask
  task automatic put(fpal_word_t w);
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_lsw_i   <= w[31:16];
    instr_msw_i   <= w[15:0];
  endtask
  task automatic idle;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask
  task automatic issue(fpal_word_t w);
    put(w);
    idle;
  endtask
  // Memory field always equals the load register number
  function automatic fpal_word_t pair(int d, int e, int f, int a);
    return {12'hE31, 3'(f), 3'(e), 3'(d), 3'(a), 5'h00, 3'(a)};
  endfunction
  function automatic fpal_word_t cmpr(int a, int b);
    return {16'hE694, 10'h000, 3'(b), 3'(a)};
  endfunction
  function automatic fpal_word_t cmpi(int a, fpal_half_t imm);
    return {10'h3A0, imm, 3'h0, 3'(a)};
  endfunction
  // R7 is scratch add target; loads never name it
  task automatic ld(int a, fpal_word_t v);
    fpal_host_mem_inst.mem_q[a] = v;
    issue(pair(7, 7, 7, a));
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    chk("flags", 32'h0, {25'h0, flags_o});
    for (int i = 0; i < 16; i++) begin
      rdchk(8'(4 * i), 32'h0, "reset read");
    end
    wr(8'h08, 32'h3);
    rdchk(8'h08, 32'h3, "mask");
    wr(8'h24, 32'hFFFF_FFFF);
    wr(8'h10, 32'hFFFF_FFFF);
    rdchk(8'h24, 32'h0, "read-only reg");
    rdchk(8'h10, 32'h0, "unmapped");
    wr(8'h08, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_load;
    fpal_word_t v [5] = '{32'h8000_0000, 32'h0, 32'hC000_0000,
                          32'h0000_0001, 32'h3F80_0000};
    fpal_word_t e;
    logic       z;
    for (int i = 0; i < 5; i++) begin
      ld(i, v[i]);
      z = v[i][30:23] == 8'h00;
      e = {28'h0, v[i] == 32'h0, v[i][31], z, v[i][31] & !z};
      chk("load flags", e, {28'h0, flags_o[5:2]});
      rdchk(8'h20 + 8'(4 * i), v[i], "loaded reg");
    end
    $display("load test done");
  endtask
  task automatic t_pipe;
    fpal_host_mem_inst.mem_q[6] = 32'h40A0_0000;
    put(pair(5, 4, 4, 6));
    put(cmpi(6, 16'h40A0));
    put(cmpi(5, 16'h4000));
    #1 chk("load seen next", 32'h2, {30'h0, flags_o[3:2]});
    idle;
    chk("sum after slot", 32'h2, {30'h0, flags_o[3:2]});
    rdchk(8'h34, 32'h4000_0000, "sum reg");
    $display("pipeline test done");
  endtask
  task automatic t_cmp;
    fpal_word_t v [7] = '{32'hC000_0000, 32'h40A0_0000, 32'h40A0_0001,
      32'h0000_0001, 32'h7FC0_0000, 32'h7F80_0000, 32'h8000_0000};
    fpal_word_t ins [13] = '{cmpr(0, 1), cmpr(1, 0), cmpr(1, 1),
      cmpr(6, 3), cmpr(3, 6), cmpr(4, 5), cmpr(1, 4), cmpi(1, 16'h40D0),
      cmpi(1, 16'h40A0), cmpi(1, 16'h4000), cmpi(6, 16'h0000),
      cmpi(2, 16'h40A0), 32'hE694_8009};
    logic [1:0] want [13] = '{2'h1, 2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1,
      2'h1, 2'h2, 2'h0, 2'h2, 2'h0, 2'h0};
    logic [4:0] keep;
    for (int i = 0; i < 7; i++) begin
      ld(i, v[i]);
    end
    wr(8'h00, 32'h40);
    keep = {flags_o[6:4], flags_o[1:0]};
    for (int i = 0; i < 13; i++) begin
      issue(ins[i]);
      chk("cmp", {30'h0, want[i]}, {30'h0, flags_o[3:2]});
      chk("cmp keep", {27'h0, keep}, {27'h0, flags_o[6:4], flags_o[1:0]});
    end
    $display("compare test done");
  endtask
  task automatic t_ovf;
    ld(0, 32'h7F00_0000);
    ld(1, 32'h00C0_0000);
    ld(2, 32'h8080_0000);
    issue(pair(3, 0, 0, 4));
    @(posedge clk_i);
    #1 chk("overflow", 32'h5, {29'h0, flags_o[6], flags_o[1:0]});
    chk("irq masked", 32'h0, {31'h0, irq_o});
    rdchk(8'h04, 32'h1, "int status");
    wr(8'h08, 32'h3);
    chk("irq", 32'h1, {31'h0, irq_o});
    wr(8'h04, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    chk("lvf held", 32'h1, {31'h0, flags_o[0]});
    wr(8'h00, 32'h41);
    chk("lvf cleared", 32'h4, {29'h0, flags_o[6], flags_o[1:0]});
    issue(pair(3, 1, 2, 4));
    @(posedge clk_i);
    #1 chk("underflow", 32'h6, {29'h0, flags_o[6], flags_o[1:0]});
    chk("irq unf", 32'h1, {31'h0, irq_o});
    rdchk(8'h04, 32'h2, "int status");
    wr(8'h04, 32'h2);
    wr(8'h00, 32'h2);
    chk("all clear", 32'h0, {29'h0, flags_o[6], flags_o[1:0]});
    chk("irq off", 32'h0, {31'h0, irq_o});
    $display("flag test done");
  endtask
  task automatic final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset;
    t_load;
    t_pipe;
    t_cmp;
    t_ovf;
    final_report;
  end
endmodule // tb
